// *** inc/ee_prog_pkg.sv ***
package ee_prog_pkg;
    // Register map (byte addresses on AHB-Lite, one word per register)
    localparam logic [15:0] CTRL_OFFSET = 16'h103B;
    // Offset above is a word index; the bus address is four times it
    localparam logic [15:0] CTRL_ADDR = 16'h40EC;
    localparam logic [15:0] STATUS_ADDR = 16'h10F0;
    localparam logic [15:0] ARRAY_BASE = 16'hB600;
    localparam int ARRAY_BYTES = 512;
    localparam int ADDR_W = 9;
    localparam int ROW_BYTES = 16;
    localparam int ROW_LSB = 4;
    // Control field positions
    localparam int HV_BIT = 0;
    localparam int LATCH_BIT = 1;
    localparam int ERASE_BIT = 2;
    localparam int ROW_BIT = 3;
    localparam int BYTE_BIT = 4;
    localparam int GAP_BIT = 5;
    localparam int EVEN_BIT = 6;
    localparam int ODD_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hDF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // Operation codes driven to the array
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_PROGRAM = 3'h1;
    localparam logic [2:0] OP_BULK = 3'h2;
    localparam logic [2:0] OP_ROW = 3'h3;
    localparam logic [2:0] OP_BYTE = 3'h4;
endpackage : ee_prog_pkg

// *** logic/ee_addr_decode.sv ***
`timescale 1ns/1ns
module ee_addr_decode (
    input wire logic [15:0] addr_in,
    output logic ctrl_hit_out,
    output logic status_hit_out,
    output logic array_hit_out
);
    logic [15:0] offs;
    assign offs = addr_in - ee_prog_pkg::ARRAY_BASE;
    assign ctrl_hit_out = addr_in == ee_prog_pkg::CTRL_ADDR;
    assign status_hit_out = addr_in == ee_prog_pkg::STATUS_ADDR;
    assign array_hit_out = (addr_in >= ee_prog_pkg::ARRAY_BASE)
        && (offs < 16'(ee_prog_pkg::ARRAY_BYTES)); // [RQ20]
endmodule : ee_addr_decode

// *** logic/ee_op_decode.sv ***
`timescale 1ns/1ns
module ee_op_decode (
    input wire logic [7:0] ctrl_in,
    output logic [2:0] op_out
);
    always_comb begin
        if (!ctrl_in[ee_prog_pkg::LATCH_BIT]) begin
            op_out = ee_prog_pkg::OP_READ; // [RQ11]
        end else if (!ctrl_in[ee_prog_pkg::ERASE_BIT]) begin
            op_out = ee_prog_pkg::OP_PROGRAM; // [RQ5] [RQ12]
        end else if (ctrl_in[ee_prog_pkg::BYTE_BIT]) begin
            op_out = ee_prog_pkg::OP_BYTE; // [RQ3]
        end else if (ctrl_in[ee_prog_pkg::ROW_BIT]) begin
            op_out = ee_prog_pkg::OP_ROW; // [RQ4]
        end else begin
            op_out = ee_prog_pkg::OP_BULK; // [RQ4]
        end
    end
endmodule : ee_op_decode

// *** logic/eeprom_program_erase_control.sv ***
`timescale 1ns/1ns
// Behaviour
// RQ1: Reset clears the whole control register.
// RQ2: Bit 5 reads zero, writes ignored.
// RQ3: Byte select restricts erase, overrides row.
// RQ4: Row bit picks bulk or row erase.
// RQ5: Erase bit picks program versus erase.
// RQ6: Latch bit captures next array write.
// RQ7: High-voltage bit drives pump enable.
// RQ8: Setting latch and voltage together sets neither.
// RQ9: Array writes ignored while voltage on.
// RQ10: Array reads blanked during program or erase.
// RQ11: Latch clear means plain read-only array.
// RQ12: Programming ignores byte and row bits.
// RQ13: Software sets pump clock under 1 MHz.
// RQ14: Programming only clears bits; erase sets.
// RQ15: Program sequence 02, data, 03, wait, clear.
// RQ16: Bulk sequence 06, any write, 07, clear.
// RQ17: Row is sixteen aligned bytes, 0E/0F.
// RQ18: Byte erase sequence 16, write, 17, clear.
// RQ19: Bits 7 and 6 restrict odd/even rows.
// RQ20: Array is 512 bytes, control register only; the code also decodes a status register at STATUS_ADDR.
// RQ21: Software allows pump clock settling time.
// RQ22: No internal timer; software ends voltage.
// RQ23: Latched address and data held until unlatch.
module eeprom_program_erase_control (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire logic [7:0] array_rdata_in,
    output logic [ee_prog_pkg::ADDR_W-1:0] array_raddr_out,
    output logic [ee_prog_pkg::ADDR_W-1:0] array_waddr_out,
    output logic [7:0] array_wdata_out,
    output logic [2:0] array_op_out,
    output logic high_voltage_enable_out,
    output logic odd_rows_out,
    output logic even_rows_out,
    output logic pump_clock_select_out
);
    localparam int AW = ee_prog_pkg::ADDR_W;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_wr;
    logic ap_valid;
    logic ctrl_hit, status_hit, array_hit;
    logic dp_write_q, dp_read_q, dp_ctrl_q, dp_status_q, dp_array_q;
    logic [AW-1:0] dp_addr_q;
    logic [AW-1:0] lat_addr_q;
    logic [7:0] lat_data_q;
    logic lat_valid_q;
    logic pump_sel_q;
    logic [2:0] op;
    logic busy;
    logic [31:0] rdata_d;
    logic read_pend_q;
    logic [15:0] offs;

    ee_addr_decode u_addr (
        .addr_in(haddr_in[15:0]),
        .ctrl_hit_out(ctrl_hit),
        .status_hit_out(status_hit),
        .array_hit_out(array_hit)
    );
    ee_op_decode u_op (
        .ctrl_in(ctrl_q),
        .op_out(op)
    );

    assign ap_valid = hsel_in && hready_in && htrans_in[1];
    assign offs = haddr_in[15:0] - ee_prog_pkg::ARRAY_BASE;
    // Program or erase is active once voltage is on with latch set
    assign busy = ctrl_q[ee_prog_pkg::HV_BIT] && ctrl_q[ee_prog_pkg::LATCH_BIT];

    // Address phase capture
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dp_write_q <= 1'b0;
            dp_read_q <= 1'b0;
            dp_ctrl_q <= 1'b0;
            dp_status_q <= 1'b0;
            dp_array_q <= 1'b0;
            dp_addr_q <= '0;
        end else if (hready_in) begin
            dp_write_q <= ap_valid && hwrite_in;
            dp_read_q <= ap_valid && !hwrite_in;
            dp_ctrl_q <= ctrl_hit;
            dp_status_q <= status_hit;
            dp_array_q <= array_hit;
            dp_addr_q <= offs[AW-1:0];
        end
    end

    // Write to control register; bit 5 masked, latch+voltage together refused
    always_comb begin
        ctrl_wr = hwdata_in[7:0] & ee_prog_pkg::CTRL_WMASK; // [RQ2]
        if (ctrl_wr[ee_prog_pkg::LATCH_BIT] && ctrl_wr[ee_prog_pkg::HV_BIT]
            && !(ctrl_q[ee_prog_pkg::LATCH_BIT] && !ctrl_q[ee_prog_pkg::HV_BIT])) begin
            ctrl_wr[ee_prog_pkg::LATCH_BIT] = 1'b0; // [RQ8]
            ctrl_wr[ee_prog_pkg::HV_BIT] = 1'b0; // [RQ8]
        end
        // Voltage with no latch would pump an unselected array
        if (!ctrl_wr[ee_prog_pkg::LATCH_BIT]) begin
            ctrl_wr[ee_prog_pkg::HV_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q <= ee_prog_pkg::CTRL_RESET; // [RQ1]
        end else if (dp_write_q && dp_ctrl_q) begin
            ctrl_q <= ctrl_wr; // [RQ7] [RQ19] [RQ22]
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pump_sel_q <= 1'b0;
        end else if (dp_write_q && dp_status_q) begin
            pump_sel_q <= hwdata_in[0];
        end
    end

    // Array write capture
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lat_addr_q <= '0;
            lat_data_q <= ee_prog_pkg::ERASED_BYTE;
            lat_valid_q <= 1'b0;
        end else if (!ctrl_q[ee_prog_pkg::LATCH_BIT]) begin
            lat_valid_q <= 1'b0; // [RQ23]
        end else if (dp_write_q && dp_array_q && !ctrl_q[ee_prog_pkg::HV_BIT]) begin
            lat_addr_q <= dp_addr_q; // [RQ6] [RQ9]
            lat_data_q <= hwdata_in[7:0]; // [RQ14]
            lat_valid_q <= 1'b1;
        end
    end

    // Array outputs to the cell block and pump
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            array_op_out <= ee_prog_pkg::OP_READ;
            high_voltage_enable_out <= 1'b0;
            array_waddr_out <= '0;
            array_wdata_out <= ee_prog_pkg::ERASED_BYTE;
            odd_rows_out <= 1'b0;
            even_rows_out <= 1'b0;
            pump_clock_select_out <= 1'b0;
            array_raddr_out <= '0;
        end else begin
            array_op_out <= op; // [RQ3] [RQ4] [RQ5] [RQ12]
            high_voltage_enable_out <= busy && lat_valid_q; // [RQ7]
            array_waddr_out <= lat_addr_q; // [RQ17] [RQ23]
            array_wdata_out <= lat_data_q;
            odd_rows_out <= ctrl_q[ee_prog_pkg::ODD_BIT]; // [RQ19]
            even_rows_out <= ctrl_q[ee_prog_pkg::EVEN_BIT]; // [RQ19]
            pump_clock_select_out <= pump_sel_q;
            if (ap_valid && !hwrite_in) begin
                array_raddr_out <= offs[AW-1:0];
            end
        end
    end

    // Reads take one wait state so the array can present data
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (dp_ctrl_q) begin
            rdata_d = {24'h000000, ctrl_q & ee_prog_pkg::CTRL_WMASK}; // [RQ2]
        end else if (dp_status_q) begin
            rdata_d = {29'h0, lat_valid_q, busy, pump_sel_q};
        end else if (dp_array_q && !ctrl_q[ee_prog_pkg::LATCH_BIT]) begin
            rdata_d = {24'h000000, array_rdata_in}; // [RQ10] [RQ11]
        end
    end

    // The wait state starts at the address edge so the master never sees stale data
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            read_pend_q <= 1'b0;
            hreadyout_out <= 1'b1;
            hrdata_out <= 32'h0000_0000;
            hresp_out <= 1'b0;
        end else begin
            read_pend_q <= 1'b0;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            if (ap_valid && !hwrite_in) begin
                read_pend_q <= 1'b1;
                hreadyout_out <= 1'b0;
            end else if (read_pend_q) begin
                hrdata_out <= rdata_d;
            end
        end
    end

    a_both_bits_refused: assert property ( // [RQ8]
        @(posedge clk_in) disable iff (rst_in)
        (dp_write_q && dp_ctrl_q && hwdata_in[1] && hwdata_in[0] && !ctrl_q[1])
        |=> !ctrl_q[0]) else $error("latch and voltage set together");

    a_gap_bit_zero: assert property ( // [RQ2]
        @(posedge clk_in) disable iff (rst_in)
        !ctrl_q[ee_prog_pkg::GAP_BIT]) else $error("bit 5 set");

    a_gap_read_zero: assert property ( // [RQ2]
        @(posedge clk_in) disable iff (rst_in)
        (read_pend_q && dp_ctrl_q) |=> !hrdata_out[5]) else $error("bit 5 read as one");

    a_latch_held_hv: assert property ( // [RQ9]
        @(posedge clk_in) disable iff (rst_in)
        (ctrl_q[0] && $past(ctrl_q[0])) |-> $stable(lat_addr_q) && $stable(lat_data_q))
        else $error("latched data moved under voltage");

    a_write_ignored_hv: assert property ( // [RQ9]
        @(posedge clk_in) disable iff (rst_in)
        (ctrl_q[0] && dp_write_q && dp_array_q) |=> $stable(lat_data_q))
        else $error("array write taken under voltage");

    a_latch_captures: assert property ( // [RQ6]
        @(posedge clk_in) disable iff (rst_in)
        (dp_write_q && dp_array_q && ctrl_q[1] && !ctrl_q[0])
        |=> lat_valid_q && lat_data_q == $past(hwdata_in[7:0]))
        else $error("array write not latched");

    a_unlatch_clears: assert property ( // [RQ23]
        @(posedge clk_in) disable iff (rst_in)
        !ctrl_q[1] |=> !lat_valid_q) else $error("latch kept after unlatch");

    a_waddr_follows: assert property ( // [RQ23]
        @(posedge clk_in) disable iff (rst_in)
        lat_valid_q |=> array_waddr_out == $past(lat_addr_q))
        else $error("target address not presented");

    a_hv_follows_ctrl: assert property ( // [RQ7]
        @(posedge clk_in) disable iff (rst_in)
        high_voltage_enable_out |-> $past(ctrl_q[0])) else $error("pump on without bit");

    a_hv_needs_latch: assert property ( // [RQ7]
        @(posedge clk_in) disable iff (rst_in)
        high_voltage_enable_out |-> $past(ctrl_q[1])) else $error("pump on without latch");

    a_hv_drops_clear: assert property ( // [RQ22]
        @(posedge clk_in) disable iff (rst_in)
        !ctrl_q[0] |=> !high_voltage_enable_out) else $error("pump left on");

    a_hv_held_on: assert property ( // [RQ22]
        @(posedge clk_in) disable iff (rst_in)
        (busy && lat_valid_q) |=> high_voltage_enable_out) else $error("pump dropped early");

    a_op_byte_wins: assert property ( // [RQ3]
        @(posedge clk_in) disable iff (rst_in)
        (ctrl_q[1] && ctrl_q[2] && ctrl_q[4]) |=> array_op_out == ee_prog_pkg::OP_BYTE)
        else $error("byte erase not selected");

    a_op_row_bulk: assert property ( // [RQ4]
        @(posedge clk_in) disable iff (rst_in)
        (ctrl_q[1] && ctrl_q[2] && !ctrl_q[4]) |=>
        array_op_out == ($past(ctrl_q[3]) ? ee_prog_pkg::OP_ROW : ee_prog_pkg::OP_BULK))
        else $error("row or bulk wrong");

    a_op_program: assert property ( // [RQ12]
        @(posedge clk_in) disable iff (rst_in)
        (ctrl_q[1] && !ctrl_q[2]) |=> array_op_out == ee_prog_pkg::OP_PROGRAM)
        else $error("program op wrong");

    a_prog_ignores_bits: assert property ( // [RQ12]
        @(posedge clk_in) disable iff (rst_in)
        (ctrl_q[1] && !ctrl_q[2] && $changed(ctrl_q[4:3]))
        |=> array_op_out == ee_prog_pkg::OP_PROGRAM) else $error("program op disturbed");

    a_read_plain: assert property ( // [RQ11]
        @(posedge clk_in) disable iff (rst_in)
        !ctrl_q[1] |=> array_op_out == ee_prog_pkg::OP_READ && !high_voltage_enable_out)
        else $error("read mode not plain");

    a_no_bare_voltage: assert property ( // [RQ11]
        @(posedge clk_in) disable iff (rst_in)
        !ctrl_q[1] |-> !ctrl_q[0]) else $error("voltage bit stored without latch");

    a_read_blanked: assert property ( // [RQ10]
        @(posedge clk_in) disable iff (rst_in)
        (read_pend_q && dp_array_q && ctrl_q[1]) |=> hrdata_out == 32'h0)
        else $error("array read while latched");

    a_read_wait_one: assert property ( // [RQ10]
        @(posedge clk_in) disable iff (rst_in)
        (ap_valid && !hwrite_in) |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait state wrong");

    a_write_no_wait: assert property ( // [RQ6]
        @(posedge clk_in) disable iff (rst_in)
        (ap_valid && hwrite_in) |=> hreadyout_out) else $error("write stalled");

    a_odd_even_copy: assert property ( // [RQ19]
        @(posedge clk_in) disable iff (rst_in)
        1'b1 |=> odd_rows_out == $past(ctrl_q[7]) && even_rows_out == $past(ctrl_q[6]))
        else $error("row test bits not copied");

    a_resp_okay: assert property ( // [RQ20]
        @(posedge clk_in) disable iff (rst_in)
        !hresp_out) else $error("error response given");
endmodule : eeprom_program_erase_control

// *** sim/ee_array_model.sv ***
`timescale 1ns/1ns
module ee_array_model (
    input wire logic clk_in,
    input wire logic [8:0] raddr_in,
    input wire logic [8:0] waddr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [2:0] op_in,
    input wire logic hv_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [512];
    logic hv_q = 1'b0;
    initial begin
        for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'h5A;
    end
    assign rdata_out = mem[raddr_in];
    // Cells change once per pump turn-on, so a held voltage works only once
    always @(posedge clk_in) begin
        hv_q <= hv_in;
        if (hv_in && !hv_q) begin
            for (int i = 0; i < 512; i++) begin
                if (op_in == ee_prog_pkg::OP_BULK) mem[i] = 8'hFF;
                if (op_in == ee_prog_pkg::OP_ROW && i[8:4] == waddr_in[8:4]) mem[i] = 8'hFF;
            end
            if (op_in == ee_prog_pkg::OP_BYTE) mem[waddr_in] = 8'hFF;
            if (op_in == ee_prog_pkg::OP_PROGRAM) mem[waddr_in] &= wdata_in;
        end
    end
endmodule : ee_array_model

// *** sim/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic rd_ph = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic hready, hresp, hv, odd, even, pump;
    logic [31:0] hrdata;
    logic [7:0] rdata, wdat, dat, sh [512];
    logic [8:0] raddr, waddr, a;
    logic [2:0] op, eop;
    logic [31:0] expq [$];
    logic [7:0] codes [6] = '{8'h02, 8'h06, 8'h0E, 8'h16, 8'h1A, 8'h1E};
    int fails = 0;
    int checks = 0;
    localparam logic [15:0] CA = ee_prog_pkg::CTRL_ADDR;
    always #2 clk_in = ~clk_in;
    eeprom_program_erase_control u_dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
        .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
        .hrdata_out(hrdata), .array_rdata_in(rdata), .array_raddr_out(raddr),
        .array_waddr_out(waddr), .array_wdata_out(wdat), .array_op_out(op),
        .high_voltage_enable_out(hv), .odd_rows_out(odd), .even_rows_out(even),
        .pump_clock_select_out(pump));
    ee_array_model u_array (.clk_in(clk_in), .raddr_in(raddr), .waddr_in(waddr),
        .wdata_in(wdat), .op_in(op), .hv_in(hv), .rdata_out(rdata));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task close_out;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    task xfer(input logic w, input logic [15:0] ad, input logic [31:0] d);
        @(posedge clk_in);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {16'h0000, ad};
        hwrite <= w;
        do @(posedge clk_in); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        rd_ph <= !w;
        do @(posedge clk_in); while (hready !== 1'b1);
        rd_ph <= 1'b0;
    endtask : xfer
    task rd(input logic [15:0] ad, input logic [31:0] e);
        expq.push_back(e);
        xfer(1'b0, ad, 32'h0);
    endtask : rd
    function automatic logic [15:0] arr(input logic [8:0] x);
        return ee_prog_pkg::ARRAY_BASE + {7'h00, x};
    endfunction : arr
    task upd(input logic [2:0] o, input logic [8:0] ad, input logic [7:0] d);
        for (int i = 0; i < 512; i++) begin
            if (o == ee_prog_pkg::OP_BULK || (o == ee_prog_pkg::OP_ROW && i[8:4] == ad[8:4]))
                sh[i] = 8'hFF;
        end
        if (o == ee_prog_pkg::OP_BYTE) sh[ad] = 8'hFF;
        if (o == ee_prog_pkg::OP_PROGRAM) sh[ad] = sh[ad] & d;
    endtask : upd
    always @(posedge clk_in) begin
        if (rd_ph && hready === 1'b1) chk(hrdata, expq.pop_front());
        if (rd_ph && hready === 1'b1) chk({31'h0, hresp}, 32'h0);
    end
    initial begin
        #100000;
        fails++;
        close_out();
    end
    initial begin
        void'($urandom(32'hD2A7E2EA));
        for (int i = 0; i < 512; i++) sh[i] = i[7:0] ^ 8'h5A;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        #1 chk({hv, op}, 32'h0);
        rd(CA, 32'h0);
        xfer(1'b1, CA, 32'hFF);
        rd(CA, 32'hDC);
        chk({odd, even}, 32'h3);
        xfer(1'b1, ee_prog_pkg::STATUS_ADDR, 32'h1);
        repeat (2) @(posedge clk_in);
        xfer(1'b1, CA, 32'h0);
        repeat (2) @(posedge clk_in);
        chk({pump, odd, even}, 32'h4);
        a = 9'($urandom);
        xfer(1'b1, arr(a), 32'h0);
        rd(arr(a), {24'h0, sh[a]});
        xfer(1'b1, 16'h2000, 32'hFF);
        rd(16'h2000, 32'h0);
        $display("test control done");
        foreach (codes[k]) begin
            a = 9'($urandom);
            dat = 8'($urandom);
            eop = !codes[k][2] ? ee_prog_pkg::OP_PROGRAM : codes[k][4] ? ee_prog_pkg::OP_BYTE
                : codes[k][3] ? ee_prog_pkg::OP_ROW : ee_prog_pkg::OP_BULK;
            xfer(1'b1, CA, {24'h0, codes[k]});
            xfer(1'b1, arr(a), {24'h0, dat});
            rd(arr(a), 32'h0);
            chk({waddr, wdat}, {a, dat});
            xfer(1'b1, CA, {24'h0, codes[k] | 8'h01});
            repeat (3) @(posedge clk_in);
            #1 chk({hv, op}, {1'b1, eop});
            xfer(1'b1, arr(a ^ 9'h1F1), {24'h0, ~dat});
            repeat (40) @(posedge clk_in);
            chk({hv, waddr, wdat}, {1'b1, a, dat});
            rd(CA, {24'h0, codes[k] | 8'h01});
            xfer(1'b1, CA, 32'h0);
            upd(eop, a, dat);
            rd(arr(a), {24'h0, sh[a]});
            rd(arr(a ^ 9'h005), {24'h0, sh[a ^ 9'h005]});
            $display("test code %h done", codes[k]);
        end
        close_out();
    end
endmodule : testbench
